// file: bench/dhi_ctrl_tb_top.sv
// Testbench: controller driven over APB, panel model on the pins.
// Assumes the design files and the panel model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "dhi_params.svh"
module dhi_ctrl_tb_top;
   import dhi_pkg::*;
   localparam int HA = 8;
   localparam int VA = 4;
   logic clk = 1'h0;
   logic srst = 1'h1;
   dhi_apb_req_t req = '0;
   logic pready, pslverr, prst_n, sel_n, wr_flag, dc_sclk, rd_n, sdi, sdo;
   logic [31:0] prdata, r;
   logic [3:0] straps;
   logic [17:0] dout;
   dhi_rgb_t rgb;
   logic use_de = 1'h1;
   logic [7:0] sdo_byte = 8'h00;
   logic e;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   always #10 clk = ~clk;
   dhi_ctrl #(.H_ACT(HA), .V_ACT(VA), .DOT_DIV(4), .SCK_HALF(4)) dut (
      .CORE_CLK(clk), .SRST(srst), .APB_REQ(req), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .STRAPS(straps),
      .PANEL_RST_N(prst_n), .SELECT_N(sel_n), .WR_FLAG(wr_flag),
      .DC_SCLK(dc_sclk), .READ_STROBE_N(rd_n), .SDI_OUT(sdi),
      .SDO_IN(sdo), .DATA_OUT(dout), .RGB(rgb));
   dhi_panel #(.H_LEAD(5), .V_LEAD(2), .H_ACT(HA), .V_ACT(VA)) panel (
      .rst_n(prst_n), .select_n(sel_n), .wr_flag(wr_flag),
      .dc_sclk(dc_sclk), .sdi(sdi), .sdo(sdo), .straps(straps),
      .data_in(dout), .rgb(rgb), .use_de(use_de), .sdo_byte(sdo_byte));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      req <= '{1'h1, 1'h0, w, a, d};
      @(posedge clk);
      req.penable <= 1'h1;
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic idle;
      do begin
         apb(1'h0, `DHI_OFF_STAT, 32'h0);
      end while (r[0] !== 1'h0);
   endtask
   function automatic logic [31:0] ctl(input logic [3:0] s,
         input logic on, input logic f18, input logic de);
      ctl = {24'h0, 1'h1, de, f18, on, s};
   endfunction
   function automatic logic [17:0] lane(input logic [3:0] s,
         input logic [17:0] w);
      case (s)
         4'h8: lane = {w[15:8], 1'h0, w[7:0], 1'h0};
         4'h9: lane = {w[7:0], 10'h0};
         4'hb: lane = {w[8:0], 9'h0};
         default: lane = w;
      endcase
   endfunction
   task automatic ser(input logic [3:0] s, input logic on,
         input logic f18, input logic de);
      logic [7:0] b;
      logic f;
      b = 8'($urandom);
      f = 1'($urandom);
      sdo_byte <= 8'($urandom);
      apb(1'h1, `DHI_OFF_CTRL, ctl(s, on, f18, de));
      apb(1'h1, `DHI_OFF_CMD, {7'h0, f, 16'h0, b});
      idle();
      chk(panel.ser_bits, (s == 4'hd) ? 9 : 8);
      if (s == 4'hd) begin
         chk(32'(panel.ser_word), 32'({f, b}));
      end else begin
         chk(32'(panel.ser_word[7:0]), 32'(b));
         chk(32'(panel.ser_flag), 32'(f));
         chk(32'(r[15:8]), 32'(sdo_byte));
      end
   endtask
   initial begin
      logic [3:0] ps [4];
      logic [17:0] w, p;
      logic f;
      ps = '{4'h8, 4'h9, 4'ha, 4'hb};
      void'($urandom(32'h31ca));
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      chk(32'(straps), 32'he);
      chk(32'({sel_n, prst_n, rd_n}), 32'h5);
      apb(1'h0, `DHI_OFF_CTRL, 32'h0);
      chk(r, 32'h4e);
      apb(1'h0, `DHI_OFF_HTIM, 32'h0);
      chk(r, 32'h0a140a);
      apb(1'h0, `DHI_OFF_VTIM, 32'h0);
      chk(r, 32'h040202);
      apb(1'h0, 8'h18, 32'h0);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      for (int i = 0; i < 4; i++) ser(i[0] ? 4'hd : 4'he, 1'h0, 1'h1, 1'h1);
      foreach (ps[i]) begin
         w = 18'($urandom);
         f = 1'($urandom);
         apb(1'h1, `DHI_OFF_CTRL, ctl(ps[i], 1'h0, 1'h1, 1'h1));
         apb(1'h1, `DHI_OFF_CMD, {7'h0, f, 6'h0, w});
         idle();
         chk(32'(panel.par_word), 32'(lane(ps[i], w)));
         chk(32'(panel.par_flag), 32'(f));
      end
      apb(1'h1, `DHI_OFF_HTIM, 32'h00020203);
      apb(1'h1, `DHI_OFF_VTIM, 32'h00030101);
      apb(1'h0, `DHI_OFF_HTIM, 32'h0);
      chk(r, 32'h00020203);
      p = 18'($urandom);
      apb(1'h1, `DHI_OFF_PIX, {14'h0, p});
      for (int m = 1; m >= 0; m--) begin
         use_de <= m[0];
         apb(1'h1, `DHI_OFF_CTRL, ctl(4'he, 1'h0, m[0], m[0]));
         apb(1'h1, `DHI_OFF_CTRL, ctl(4'he, 1'h1, m[0], m[0]));
         repeat (1700) @(posedge clk);
         chk(panel.hs_len, 3);
         chk(panel.npx, HA);
         chk(panel.vl, VA);
         chk(32'(panel.px0), m[0] ? 32'(p) :
            32'({p[15:11], 1'h0, p[10:0], 1'h0}));
         ser(4'he, 1'h1, m[0], m[0]);
      end
      chk(32'(rgb.de), 32'h0);
      complete_run();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
endmodule
`default_nettype wire

// file: bench/dhi_panel.sv
// Panel model: serial, parallel and RGB receive side of the display.
// Assumes the controller pins are wired straight to it.
`timescale 1ns/10ps
`default_nettype none
module dhi_panel #(
   parameter int H_LEAD = 5,
   parameter int V_LEAD = 2,
   parameter int H_ACT = 8,
   parameter int V_ACT = 4
) (
   input wire logic rst_n,
   input wire logic select_n,
   input wire logic wr_flag,
   input wire logic dc_sclk,
   input wire logic sdi,
   output logic sdo,
   input wire logic [3:0] straps,
   input wire logic [17:0] data_in,
   input wire dhi_pkg::dhi_rgb_t rgb,
   input wire logic use_de,
   input wire logic [7:0] sdo_byte
);
   import dhi_pkg::*;
   logic [8:0] sh, ser_word;
   logic [7:0] tx;
   logic [17:0] par_word, px0;
   logic ser_flag, par_flag;
   logic hs_q = 1'h1;
   logic vs_q = 1'h1;
   int nbit, ser_bits, dot, ln, lpx, npx, nl, vl, hs_len;
   wire ser = straps[3:2] == 2'h3;
   initial sdo = 1'h0;
   always @(negedge rst_n) begin
      nbit = 0;
      lpx = 0;
   end
   always @(negedge select_n) begin
      nbit = 0;
      tx = sdo_byte;
      sdo = tx[7];
   end
   always @(posedge dc_sclk) begin
      if (!select_n && ser) begin
         sh = {sh[7:0], sdi};
         nbit = nbit + 1;
         if (nbit == 1) ser_flag = wr_flag;
      end
   end
   always @(negedge dc_sclk) begin
      if (!select_n && ser && nbit != 0) begin
         tx = {tx[6:0], 1'h0};
         sdo = tx[7];
      end
   end
   always @(posedge select_n) begin
      if (ser) begin
         ser_bits = nbit;
         ser_word = sh;
      end
      // Released line must not keep its last value
      sdo = ~sdo;
   end
   always @(posedge wr_flag) begin
      if (straps[3:2] == 2'h2 && !select_n) begin
         par_word = data_in;
         par_flag = dc_sclk;
      end
   end
   always @(posedge rgb.pixel_clock) begin
      dot = (hs_q && !rgb.hsync_n) ? 1 : dot + 1;
      if (!hs_q && rgb.hsync_n) hs_len = dot - 1;
      if (hs_q && !rgb.hsync_n) begin
         if (lpx != 0) begin
            npx = lpx;
            nl = nl + 1;
         end
         lpx = 0;
         if (!rgb.vsync_n && vs_q) begin
            vl = nl;
            nl = 0;
            ln = 1;
         end else begin
            ln = ln + 1;
         end
         vs_q = rgb.vsync_n;
      end
      hs_q = rgb.hsync_n;
      if (use_de ? rgb.de : (dot > H_LEAD && dot <= H_LEAD + H_ACT &&
            ln > V_LEAD && ln <= V_LEAD + V_ACT)) begin
         if (lpx == 0) px0 = data_in;
         lpx = lpx + 1;
      end
   end
endmodule
`default_nettype wire

// file: logic/dhi_ctrl.sv
// Host controller for a small TFT panel: serial or parallel command link
// and an RGB pixel port with programmable sync and porch widths.
// Assumes an APB master on CORE_CLK and the panel wired to the pins.
//
// Notes on behaviour
// - Strap code picks host bus: 8 16-bit, 9 8-bit, a 18-bit, b 9-bit.
// - Strap d gives 3-wire serial with 9-bit words, e 4-wire with 8-bit.
// - In serial modes DC_SCLK pin is clock; 4-wire mode uses write strobe pin as flag.
// - Host lowers select, flag bit goes first, sampled on first rise.
// - Data changes on falling clock, MSB first; device samples rising.
// - 4-wire mode: exactly eight clocks per byte, no embedded flag.
// - Line: sync 2-16, back porch 2-24, 240 pixels, front 2-16 dots.
// - Frame: sync 1-4, back porch 1+, 320 lines, front porch 3+ lines.
// - Timing uses all polarities zero: low syncs, data on falling dot.
// - RGB format 110 uses all eighteen data lines.
// - RGB format 101 uses D17..D13 and D11..D1.
// - In 16-bit RGB mode D12 and D0 are held low.
// - Serial command link stays usable while RGB port streams.
`timescale 1ns/10ps
`default_nettype none
`include "dhi_params.svh"
module dhi_ctrl #(
   parameter int unsigned H_ACT = `DHI_H_ACT,
   parameter int unsigned V_ACT = `DHI_V_ACT,
   parameter int unsigned DOT_DIV = `DHI_DOT_DIV,
   parameter int unsigned SCK_HALF = `DHI_SCK_HALF
) (
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire dhi_pkg::dhi_apb_req_t APB_REQ,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   output logic [3:0] STRAPS,
   output logic PANEL_RST_N,
   output logic SELECT_N,
   output logic WR_FLAG,
   output logic DC_SCLK,
   output logic READ_STROBE_N,
   output logic SDI_OUT,
   input wire logic SDO_IN,
   output logic [17:0] DATA_OUT,
   output var dhi_pkg::dhi_rgb_t RGB
);
   import dhi_pkg::*;

   logic [7:0] ctrl_q;
   logic [23:0] htim_q, vtim_q;
   logic pready_q, pslverr_q, rd_n_q;
   logic [31:0] prdata_q;
   dhi_state_t st_q;
   logic [7:0] tmr_q, rx_q, dcnt_q;
   logic [3:0] bits_q, rc_q;
   logic [8:0] sh_q;
   logic sel_n_q, wrf_q, dcs_q, sdi_q, flag_q, ser3_q, ser4_q;
   logic sdo_m_q, sdo_s_q;
   logic [17:0] data_q, rd_pix;
   logic pclk_q, hs_n_q, vs_n_q, de_q, vact_q;
   logic [10:0] hcnt_q, vcnt_q;

   // Bus decode
   wire [7:0] addr = APB_REQ.paddr;
   wire acc = APB_REQ.psel & APB_REQ.penable;
   wire take = acc & pready_q;
   wire wr = take & APB_REQ.pwrite;
   wire h_ctrl = addr == `DHI_OFF_CTRL;
   wire h_cmd = addr == `DHI_OFF_CMD;
   wire h_stat = addr == `DHI_OFF_STAT;
   wire h_htim = addr == `DHI_OFF_HTIM;
   wire h_vtim = addr == `DHI_OFF_VTIM;
   wire h_pix = addr == `DHI_OFF_PIX;
   wire mapped = h_ctrl | h_cmd | h_stat | h_htim | h_vtim | h_pix;
   wire busy = st_q != ST_IDLE;
   wire [31:0] stat_w = {16'h0, rx_q, 6'h0, vact_q, busy};
   wire [31:0] rd_w = h_ctrl ? {24'h0, ctrl_q} :
                      h_stat ? stat_w :
                      h_htim ? {8'h0, htim_q} :
                      h_vtim ? {8'h0, vtim_q} : 32'h0;

   // Mode selection
   wire [3:0] strap = ctrl_q[`DHI_C_STRAP];
   wire rgb_en = ctrl_q[`DHI_C_RGB];
   wire f18 = ctrl_q[`DHI_C_F18];
   wire de_en = ctrl_q[`DHI_C_DE];
   wire m3 = strap == `DHI_IM_S3;
   wire m4 = strap == `DHI_IM_S4;
   wire ser = ser3_q | ser4_q;

   // Command launch; refused silently while a transfer runs
   wire go = wr & h_cmd & ~busy;
   wire [17:0] w = APB_REQ.pwdata[`DHI_W_WORD];
   wire fl = APB_REQ.pwdata[`DHI_W_FLAG];
   wire [8:0] sh_ld = m3 ? {fl, w[7:0]} : {w[7:0], 1'b0};
   wire [3:0] nbits = m3 ? `DHI_SER3_BITS : m4 ? `DHI_SER4_BITS : 4'h1;
   wire [17:0] par_w = (strap == `DHI_IM_P16) ?
                       {w[15:8], 1'b0, w[7:0], 1'b0} :
                       (strap == `DHI_IM_P8) ? {w[7:0], 10'h0} :
                       (strap == `DHI_IM_P9) ? {w[8:0], 9'h0} : w;
   wire tmr_end = tmr_q == 8'(SCK_HALF - 1);
   wire e_rise = (st_q == ST_LO) & tmr_end;
   wire e_hi_end = (st_q == ST_HI) & tmr_end;
   wire e_fall = e_hi_end & (bits_q != 4'h1);
   wire e_done = (st_q == ST_END) & tmr_end;

   // Line and frame geometry
   wire [10:0] hs = {3'h0, htim_q[`DHI_T_SYNC]};
   wire [10:0] h_lo = hs + {3'h0, htim_q[`DHI_T_BP]};
   wire [10:0] h_hi = h_lo + 11'(H_ACT);
   wire [10:0] h_tot = h_hi + {3'h0, htim_q[`DHI_T_FP]};
   wire [10:0] vs = {3'h0, vtim_q[`DHI_T_SYNC]};
   wire [10:0] v_lo = vs + {3'h0, vtim_q[`DHI_T_BP]};
   wire [10:0] v_hi = v_lo + 11'(V_ACT);
   wire [10:0] v_tot = v_hi + {3'h0, vtim_q[`DHI_T_FP]};
   wire h_wrap = hcnt_q == h_tot - 11'h1;
   wire v_wrap = vcnt_q == v_tot - 11'h1;
   wire [10:0] h_nx = h_wrap ? 11'h0 : hcnt_q + 11'h1;
   wire [10:0] v_nx = !h_wrap ? vcnt_q : v_wrap ? 11'h0 : vcnt_q + 11'h1;
   wire v_act = (v_nx >= v_lo) && (v_nx < v_hi);
   wire act_nx = (h_nx >= h_lo) && (h_nx < h_hi) && v_act;
   wire [10:0] col = h_nx - h_lo;
   wire dhalf = dcnt_q == 8'(DOT_DIV / 2 - 1);
   wire dend = dcnt_q == 8'(DOT_DIV - 1);
   wire [17:0] pix_map = f18 ? rd_pix :
                         {rd_pix[15:11], 1'b0, rd_pix[10:0], 1'b0};

   // Column address is settled a whole dot before its data is needed
   dhi_mem #(.W(18), .AW(8)) u_line (
      .clk(CORE_CLK),
      .we(wr & h_pix),
      .waddr(APB_REQ.pwdata[`DHI_P_ADDR]),
      .wdata(APB_REQ.pwdata[`DHI_P_DATA]),
      .raddr(col[7:0]),
      .rdata(rd_pix)
   );

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~mapped;
         prdata_q <= (acc & ~pready_q & ~APB_REQ.pwrite) ? rd_w : 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         ctrl_q <= `DHI_CTRL_RST;
         htim_q <= `DHI_HTIM_RST;
         vtim_q <= `DHI_VTIM_RST;
      end else begin
         if (wr & h_ctrl) ctrl_q <= APB_REQ.pwdata[7:0];
         if (wr & h_htim) htim_q <= APB_REQ.pwdata[23:0];
         if (wr & h_vtim) vtim_q <= APB_REQ.pwdata[23:0];
      end
   end

   // Device output is asynchronous to us
   always_ff @(posedge CORE_CLK) begin
      sdo_m_q <= SDO_IN;
      sdo_s_q <= sdo_m_q;
      rd_n_q <= 1'b1;
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         st_q <= ST_IDLE;
         tmr_q <= 8'h0;
      end else begin
         tmr_q <= (go || tmr_end) ? 8'h0 : tmr_q + 8'h1;
         case (st_q)
            ST_IDLE: if (go) st_q <= ST_LO;
            ST_LO: if (tmr_end) st_q <= ST_HI;
            ST_HI: if (tmr_end) st_q <= (bits_q == 4'h1) ? ST_END : ST_LO;
            ST_END: if (tmr_end) st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Pins shared by parallel and serial use
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         sel_n_q <= 1'b1;
         wrf_q <= 1'b1;
         dcs_q <= 1'b1;
      end else begin
         if (go) sel_n_q <= 1'b0;
         else if (e_done) sel_n_q <= 1'b1;
         if (go) wrf_q <= m4 ? fl : m3;
         else if (e_rise & ~ser) wrf_q <= 1'b1;
         if (go) dcs_q <= (m3 | m4) ? 1'b0 : fl;
         else if (e_rise & ser) dcs_q <= 1'b1;
         else if (e_fall & ser) dcs_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         sh_q <= 9'h0;
         sdi_q <= 1'b0;
         bits_q <= 4'h0;
         rc_q <= 4'h0;
         rx_q <= 8'h0;
      end else if (go) begin
         sdi_q <= sh_ld[8];
         sh_q <= {sh_ld[7:0], 1'b0};
         bits_q <= nbits;
         rc_q <= 4'h0;
      end else begin
         if (e_rise & ser) rc_q <= rc_q + 4'h1;
         if (e_hi_end) bits_q <= bits_q - 4'h1;
         if (e_hi_end & ser) rx_q <= {rx_q[6:0], sdo_s_q};
         if (e_fall & ser) sdi_q <= sh_q[8];
         if (e_fall & ser) sh_q <= {sh_q[7:0], 1'b0};
      end
   end

   // Serial launch is never held off by the pixel port
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         flag_q <= 1'b0;
         ser3_q <= 1'b0;
         ser4_q <= 1'b0;
      end else if (go) begin
         flag_q <= fl;
         ser3_q <= m3;
         ser4_q <= m4;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST || !rgb_en) begin
         dcnt_q <= 8'h0;
         pclk_q <= 1'b0;
      end else begin
         dcnt_q <= dend ? 8'h0 : dcnt_q + 8'h1;
         if (dhalf) pclk_q <= 1'b1;
         else if (dend) pclk_q <= 1'b0;
      end
   end

   // Parked at the last dot so the first frame starts whole
   always_ff @(posedge CORE_CLK) begin
      if (SRST || !rgb_en) begin
         hcnt_q <= h_tot - 11'h1;
         vcnt_q <= v_tot - 11'h1;
      end else if (dend) begin
         hcnt_q <= h_nx;
         vcnt_q <= v_nx;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST || !rgb_en) begin
         hs_n_q <= 1'b1;
         vs_n_q <= 1'b1;
         de_q <= 1'b0;
         vact_q <= 1'b0;
      end else if (dend) begin
         hs_n_q <= !(h_nx < hs);
         vs_n_q <= !(v_nx < vs);
         de_q <= act_nx & de_en;
         vact_q <= v_act;
      end
   end

   // Parallel word or pixel; no read-back on the data lines
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         data_q <= 18'h0;
      end else if (rgb_en) begin
         if (dend) data_q <= act_nx ? pix_map : 18'h0;
      end else if (go & ~(m3 | m4)) begin
         data_q <= par_w;
      end
   end

   assign PREADY = pready_q;
   assign PRDATA = prdata_q;
   assign PSLVERR = pslverr_q;
   assign STRAPS = ctrl_q[`DHI_C_STRAP];
   assign PANEL_RST_N = ctrl_q[`DHI_C_PRST];
   assign SELECT_N = sel_n_q;
   assign WR_FLAG = wrf_q;
   assign DC_SCLK = dcs_q;
   assign READ_STROBE_N = rd_n_q;
   assign SDI_OUT = sdi_q;
   assign DATA_OUT = data_q;
   assign RGB = {vs_n_q, hs_n_q, de_q, pclk_q};

   // Checking helpers
   logic [11:0] hs_cyc_q, de_cyc_q;
   logic [10:0] vs_ln_q;
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         hs_cyc_q <= 12'h0;
         de_cyc_q <= 12'h0;
         vs_ln_q <= 11'h0;
      end else begin
         hs_cyc_q <= hs_n_q ? 12'h0 : hs_cyc_q + 12'h1;
         de_cyc_q <= de_q ? de_cyc_q + 12'h1 : 12'h0;
         if (vs_n_q) vs_ln_q <= 11'h0;
         else if (dend & h_wrap) vs_ln_q <= vs_ln_q + 11'h1;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   AST_PAR8_LANES: assert property (
      (!rgb_en && !sel_n_q && !wrf_q && !ser && strap == `DHI_IM_P8)
      |-> data_q[9:0] == 10'h0) else $error("8-bit word off its lanes");
   AST_SER3_NINE: assert property (
      $rose(sel_n_q) && ser3_q |-> rc_q == 4'h9)
      else $error("3-wire word not nine clocks");
   AST_SER4_FLAG_PIN: assert property (
      !sel_n_q && $past(!sel_n_q) && ser4_q |-> wrf_q == flag_q)
      else $error("flag pin moved inside a byte");
   AST_FLAG_FIRST: assert property (
      ser3_q && e_rise && bits_q == 4'h9 |=> dcs_q && sdi_q == flag_q)
      else $error("first rising clock not on flag bit");
   AST_DATA_ON_LOW: assert property (
      !sel_n_q && ser && $changed(sdi_q) |-> !dcs_q)
      else $error("serial data moved while clock high");
   AST_SER4_EIGHT: assert property (
      $rose(sel_n_q) && ser4_q |-> rc_q == 4'h8)
      else $error("4-wire byte not eight clocks");
   AST_HSYNC_WIDTH: assert property (
      rgb_en && $rose(hs_n_q) |-> hs_cyc_q == hs * DOT_DIV)
      else $error("line sync width wrong");
   AST_DE_WIDTH: assert property (
      rgb_en && $fell(de_q) |-> de_cyc_q == H_ACT * DOT_DIV)
      else $error("active line length wrong");
   AST_VSYNC_LINES: assert property (
      rgb_en && $rose(vs_n_q) |-> vs_ln_q == vs)
      else $error("frame sync line count wrong");
   AST_DE_OUTSIDE_SYNC: assert property (
      de_q |-> hs_n_q && vs_n_q) else $error("valid strobe during sync");
   AST_RGB16_GROUND: assert property (
      rgb_en && !f18 && dend |=> !data_q[12] && !data_q[0])
      else $error("unused RGB lines driven high");

   COV_SER3: cover property ($rose(sel_n_q) && ser3_q);
   COV_SER4: cover property ($rose(sel_n_q) && ser4_q);
   COV_FRAME: cover property (rgb_en && $fell(vs_n_q));
   COV_CMD_DURING_RGB: cover property ($fell(sel_n_q) && rgb_en && ser);
endmodule
`default_nettype wire

// file: logic/dhi_mem.sv
// Pixel line store for the RGB port: one write port, registered read.
// Assumes writer and reader share one clock.
`timescale 1ns/10ps
`default_nettype none
module dhi_mem #(
   parameter int unsigned W = 18,
   parameter int unsigned AW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem_q [0:(1<<AW)-1];
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata <= mem_q[raddr];
   end
endmodule
`default_nettype wire

// file: logic/dhi_params.svh
// Register map, field positions, reset values and link constants of the
// display host controller. Definitions only; included by the design files.
`ifndef DHI_PARAMS_SVH
`define DHI_PARAMS_SVH
`define DHI_OFF_CTRL 8'h00
`define DHI_OFF_CMD 8'h04
`define DHI_OFF_STAT 8'h08
`define DHI_OFF_HTIM 8'h0c
`define DHI_OFF_VTIM 8'h10
`define DHI_OFF_PIX 8'h14
`define DHI_CTRL_RST 8'h4e
`define DHI_HTIM_RST 24'h0a140a
`define DHI_VTIM_RST 24'h040202
`define DHI_C_STRAP 3:0
`define DHI_C_RGB 4
`define DHI_C_F18 5
`define DHI_C_DE 6
`define DHI_C_PRST 7
`define DHI_T_SYNC 7:0
`define DHI_T_BP 15:8
`define DHI_T_FP 23:16
`define DHI_W_WORD 17:0
`define DHI_W_FLAG 24
`define DHI_P_ADDR 31:24
`define DHI_P_DATA 17:0
`define DHI_IM_P16 4'h8
`define DHI_IM_P8 4'h9
`define DHI_IM_P18 4'ha
`define DHI_IM_P9 4'hb
`define DHI_IM_S3 4'hd
`define DHI_IM_S4 4'he
`define DHI_SER3_BITS 4'h9
`define DHI_SER4_BITS 4'h8
`define DHI_H_ACT 240
`define DHI_V_ACT 320
`define DHI_DOT_DIV 8
`define DHI_SCK_HALF 4
`endif

// file: logic/dhi_pkg.sv
// Types shared by the display host controller and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package dhi_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LO = 4'h2,
      ST_HI = 4'h4,
      ST_END = 4'h8
   } dhi_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } dhi_apb_req_t;
   typedef struct packed {
      logic vsync_n;
      logic hsync_n;
      logic de;
      logic pixel_clock;
   } dhi_rgb_t;
endpackage
